// >>> src/bax_pkg.sv
`default_nettype none
package bax_pkg;

  // time base: one device clock period stands for one oscillator period
  localparam int CLK_PERIOD_NS = 5;
  localparam int OSC_PERIODS_PER_CYCLE = 4;
  localparam int CLKS_PER_CYCLE = OSC_PERIODS_PER_CYCLE;

  localparam int FILE_ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;

  // register port map
  localparam logic [7:0] ADDR_FILE_LAST = 8'h7f;
  localparam logic [7:0] ADDR_ACC = 8'h80;
  localparam logic [7:0] ADDR_STATUS = 8'h81;
  localparam logic [7:0] ADDR_CORE = 8'h82;

  // status fields
  localparam int STAT_CARRY = 0;
  localparam int STAT_DIGIT_CARRY = 1;
  localparam int STAT_ZERO = 2;
  localparam int STAT_POWERDOWN_N = 3;
  localparam int STAT_TIMEOUT_N = 4;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] ACC_RESET = 8'h00;

  // core register fields (read only)
  localparam int CORE_SLEEPING = 0;
  localparam int CORE_DISCARD = 1;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ADD_IMMEDIATE_TO_ACC = 4'h1,
    OP_ADD_ACC_TO_FILE = 4'h2,
    OP_FILE_BIT_CLEAR = 4'h3,
    OP_FILE_BIT_SET = 4'h4,
    OP_AND_IMMEDIATE_WITH_ACC = 4'h5,
    OP_AND_ACC_WITH_FILE = 4'h6,
    OP_TEST_BIT_SKIP_WHEN_ONE = 4'h7,
    OP_TEST_BIT_SKIP_WHEN_ZERO = 4'h8,
    OP_ROTATE_LEFT_VIA_CARRY = 4'h9,
    OP_ROTATE_RIGHT_VIA_CARRY = 4'ha,
    OP_SLEEP = 4'hb,
    OP_RETURN = 4'hc,
    OP_IMMEDIATE_MINUS_ACC = 4'hd,
    OP_FILE_MINUS_ACC = 4'he
  } bax_op_e;

  // quarter phases of one instruction cycle, gray coded
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } bax_phase_e;

  typedef struct packed {
    bax_op_e op;
    logic [FILE_ADDR_W-1:0] faddr;
    logic dest;
    logic [2:0] bsel;
    logic [7:0] lit;
  } bax_instr_s;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic digit_c;
    logic z;
    logic upd_c;
    logic upd_digit_c;
    logic upd_z;
  } bax_alu_s;

  function automatic logic [7:0] bax_bit_mask(input logic [2:0] b);
    bax_bit_mask = 8'h01 << b;
  endfunction

endpackage
`default_nettype wire

// >>> src/bax_alu.sv
`default_nettype none
module bax_alu (
  input wire bax_pkg::bax_op_e op,
  input wire logic [7:0] acc,
  input wire logic [7:0] fval,
  input wire logic [7:0] lit,
  input wire logic [2:0] bsel,
  input wire logic carry_in,
  output var bax_pkg::bax_alu_s result
);

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] src;

  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    src = fval;
    result = '0;
    unique case (op)
      bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, bax_pkg::OP_AND_IMMEDIATE_WITH_ACC,
      bax_pkg::OP_IMMEDIATE_MINUS_ACC: begin
        src = lit;
      end
      default: begin
        src = fval;
      end
    endcase
    unique case (op)
      bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, bax_pkg::OP_ADD_ACC_TO_FILE: begin
        sum = {1'b0, acc} + {1'b0, src};
        nib = {1'b0, acc[3:0]} + {1'b0, src[3:0]};
        result.upd_c = 1'b1;
        result.upd_digit_c = 1'b1;
        result.upd_z = 1'b1;
      end
      bax_pkg::OP_IMMEDIATE_MINUS_ACC, bax_pkg::OP_FILE_MINUS_ACC: begin
        // carry out of src + ~acc + 1 is the no-borrow flag
        sum = {1'b0, src} + {1'b0, ~acc} + 9'h001;
        nib = {1'b0, src[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
        result.upd_c = 1'b1;
        result.upd_digit_c = 1'b1;
        result.upd_z = 1'b1;
      end
      bax_pkg::OP_AND_IMMEDIATE_WITH_ACC, bax_pkg::OP_AND_ACC_WITH_FILE: begin
        sum = {1'b0, acc & src};
        result.upd_z = 1'b1;
      end
      bax_pkg::OP_FILE_BIT_CLEAR: begin
        sum = {1'b0, fval & ~bax_pkg::bax_bit_mask(bsel)};
      end
      bax_pkg::OP_FILE_BIT_SET: begin
        sum = {1'b0, fval | bax_pkg::bax_bit_mask(bsel)};
      end
      bax_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
        sum = {fval[7], fval[6:0], carry_in};
        result.upd_c = 1'b1;
      end
      bax_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
        sum = {fval[0], carry_in, fval[7:1]};
        result.upd_c = 1'b1;
      end
      default: begin
        sum = {1'b0, fval};
      end
    endcase
    result.res = sum[7:0];
    result.c = sum[8];
    result.digit_c = nib[4];
    result.z = (sum[7:0] == 8'h00);
  end

endmodule
`default_nettype wire

// >>> src/bax_core.sv
`default_nettype none
// Contract
// RULE1: file-operand ops take 7-bit address; dest 0 writes acc, dest 1 writes file.
// RULE2: add immediate to acc, result to acc, update carry, digit carry, zero.
// RULE3: add acc to file register, result to destination, update carry, digit carry, zero.
// RULE4: bit clear forces selected file bit to zero, flags untouched.
// RULE5: bit set forces selected file bit to one, flags untouched.
// RULE6: AND immediate with acc into acc, only zero flag changes.
// RULE7: AND acc with file into destination, only zero flag changes.
// RULE8: skip-when-one discards next instruction as a nop if bit is one.
// RULE9: skip-when-zero discards next instruction as a nop if bit is zero.
// RULE10: rotate left through carry into destination, only carry changes.
// RULE11: rotate right through carry into destination, only carry changes.
// RULE12: sleep clears watchdog and prescaler, sets timeout_n, clears powerdown_n, halts.
// RULE13: return pops stack top into program counter, flags kept, two cycles.
// RULE14: immediate minus acc into acc, two's complement, update carry, digit carry, zero.
// RULE15: file minus acc into destination, two's complement, update carry, digit carry, zero.
// RULE16: one instruction cycle is exactly four oscillator periods.
// RULE17: zero on all-zero result; carry and digit carry from bits 7 and 3.
// RULE18: rotates shift old carry in and the bit shifted out becomes carry.
module bax_core #(
  parameter int STACK_DEPTH = bax_pkg::STACK_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_valid,
  input wire bax_pkg::bax_instr_s instr,
  output logic instr_ready,
  input wire logic call_push,
  input wire logic [bax_pkg::PC_W-1:0] call_pc,
  output logic pc_load,
  output logic [bax_pkg::PC_W-1:0] pc_value,
  output logic watchdog_clear,
  output logic sleeping,
  input wire logic wake,
  output logic [7:0] acc,
  output logic [7:0] status,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  bax_pkg::bax_phase_e phase;
  bax_pkg::bax_alu_s alu;
  logic [7:0] file_mem [bax_pkg::FILE_DEPTH];
  logic [bax_pkg::PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] sp;
  logic discard;
  logic taken;
  logic exec;
  logic [7:0] fval;
  logic fbit;
  logic file_op;
  logic wr_file;
  logic wr_acc;
  logic skip;

  // instruction cycle divider; frozen while the oscillator is halted
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= bax_pkg::PH_Q1;
    end else if (!sleeping) begin
      unique case (phase)
        bax_pkg::PH_Q1: phase <= bax_pkg::PH_Q2; // [RULE16]
        bax_pkg::PH_Q2: phase <= bax_pkg::PH_Q3;
        bax_pkg::PH_Q3: phase <= bax_pkg::PH_Q4;
        bax_pkg::PH_Q4: phase <= bax_pkg::PH_Q1;
      endcase
    end
  end

  assign instr_ready = (phase == bax_pkg::PH_Q4) && !sleeping; // [RULE16]
  assign taken = instr_ready && instr_valid;
  // an instruction taken while discard is set runs as a nop
  assign exec = taken && !discard;

  assign fval = file_mem[instr.faddr]; // [RULE1]
  assign fbit = |(fval & bax_pkg::bax_bit_mask(instr.bsel));

  bax_alu u_alu (
    .op(instr.op),
    .acc(acc),
    .fval(fval),
    .lit(instr.lit),
    .bsel(instr.bsel),
    .carry_in(status[bax_pkg::STAT_CARRY]),
    .result(alu)
  );

  always_comb begin
    file_op = 1'b0;
    unique case (instr.op)
      bax_pkg::OP_ADD_ACC_TO_FILE, bax_pkg::OP_AND_ACC_WITH_FILE,
      bax_pkg::OP_ROTATE_LEFT_VIA_CARRY, bax_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
      bax_pkg::OP_FILE_MINUS_ACC: file_op = 1'b1;
      default: file_op = 1'b0;
    endcase
  end

  always_comb begin
    wr_acc = 1'b0;
    wr_file = 1'b0;
    unique case (instr.op)
      bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, bax_pkg::OP_AND_IMMEDIATE_WITH_ACC,
      bax_pkg::OP_IMMEDIATE_MINUS_ACC: wr_acc = exec; // [RULE2] [RULE6] [RULE14]
      bax_pkg::OP_FILE_BIT_CLEAR, bax_pkg::OP_FILE_BIT_SET: wr_file = exec; // [RULE4] [RULE5]
      default: begin
        wr_acc = exec && file_op && !instr.dest; // [RULE1]
        wr_file = exec && file_op && instr.dest; // [RULE1]
      end
    endcase
  end

  always_comb begin
    skip = 1'b0;
    unique case (instr.op)
      bax_pkg::OP_TEST_BIT_SKIP_WHEN_ONE: skip = fbit; // [RULE8]
      bax_pkg::OP_TEST_BIT_SKIP_WHEN_ZERO: skip = !fbit; // [RULE9]
      bax_pkg::OP_RETURN: skip = 1'b1; // [RULE13]
      default: skip = 1'b0;
    endcase
  end

  // second cycle of a skip or return: the fetched successor is thrown away
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      discard <= 1'b0;
    end else if (taken) begin
      discard <= exec && skip; // [RULE8] [RULE9] [RULE13]
    end
  end

  // no reset on the file array: it is plain data storage
  always_ff @(posedge clk_sys) begin
    if (wr_file) begin
      file_mem[instr.faddr] <= alu.res; // [RULE1] [RULE3] [RULE4] [RULE5]
    end else if (bus_wr && !bus_addr[7]) begin
      file_mem[bus_addr[6:0]] <= bus_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc <= bax_pkg::ACC_RESET;
    end else if (wr_acc) begin
      acc <= alu.res; // [RULE2] [RULE6] [RULE7] [RULE14] [RULE15]
    end else if (bus_wr && bus_addr == bax_pkg::ADDR_ACC) begin
      acc <= bus_wdata;
    end
  end

  // hardware flag updates win over a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status <= bax_pkg::STATUS_RESET;
    end else begin
      if (bus_wr && bus_addr == bax_pkg::ADDR_STATUS) begin
        status <= bus_wdata;
      end
      if (exec && alu.upd_c) begin
        status[bax_pkg::STAT_CARRY] <= alu.c; // [RULE10] [RULE11] [RULE17] [RULE18]
      end
      if (exec && alu.upd_digit_c) begin
        status[bax_pkg::STAT_DIGIT_CARRY] <= alu.digit_c; // [RULE3] [RULE15] [RULE17]
      end
      if (exec && alu.upd_z) begin
        status[bax_pkg::STAT_ZERO] <= alu.z; // [RULE7] [RULE17]
      end
      if (exec && instr.op == bax_pkg::OP_SLEEP) begin
        status[bax_pkg::STAT_TIMEOUT_N] <= 1'b1; // [RULE12]
        status[bax_pkg::STAT_POWERDOWN_N] <= 1'b0; // [RULE12]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sleeping <= 1'b0;
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= exec && instr.op == bax_pkg::OP_SLEEP; // [RULE12]
      if (exec && instr.op == bax_pkg::OP_SLEEP) begin
        sleeping <= 1'b1; // [RULE12]
      end else if (wake) begin
        sleeping <= 1'b0;
      end
    end
  end

  // circular stack; a pop in the same cycle as a push drops the push
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sp <= '0;
      pc_load <= 1'b0;
      pc_value <= '0;
    end else begin
      pc_load <= 1'b0;
      if (exec && instr.op == bax_pkg::OP_RETURN) begin
        sp <= sp - 1'b1; // [RULE13]
        pc_load <= 1'b1;
        pc_value <= stack_mem[sp - 1'b1]; // [RULE13]
      end else if (call_push) begin
        sp <= sp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (call_push && !(exec && instr.op == bax_pkg::OP_RETURN)) begin
      stack_mem[sp] <= call_pc;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_rdata <= 8'h00;
    end else if (!bus_rd) begin
      bus_rdata <= 8'h00;
    end else if (!bus_addr[7]) begin
      bus_rdata <= file_mem[bus_addr[6:0]];
    end else if (bus_addr == bax_pkg::ADDR_ACC) begin
      bus_rdata <= acc;
    end else if (bus_addr == bax_pkg::ADDR_STATUS) begin
      bus_rdata <= status;
    end else if (bus_addr == bax_pkg::ADDR_CORE) begin
      bus_rdata <= {6'h00, discard, sleeping};
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  property p_cycle_length;
    @(posedge clk_sys) disable iff (rst)
    taken |=> !instr_ready [*3];
  endproperty
  a_cycle_length: assert property (p_cycle_length) else $error("ready inside a cycle"); // [RULE16]

  property p_add_imm;
    @(posedge clk_sys) disable iff (rst)
    exec && instr.op == bax_pkg::OP_ADD_IMMEDIATE_TO_ACC
    |=> acc == 8'($past(acc) + $past(instr.lit))
        && status[bax_pkg::STAT_ZERO] == (acc == 8'h00);
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("bad immediate add"); // [RULE2]

  property p_sub_carry;
    @(posedge clk_sys) disable iff (rst)
    exec && instr.op == bax_pkg::OP_IMMEDIATE_MINUS_ACC
    |=> status[bax_pkg::STAT_CARRY] == ($past(instr.lit) >= $past(acc));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("bad borrow flag"); // [RULE14]

  property p_bit_clear;
    @(posedge clk_sys) disable iff (rst)
    exec && instr.op == bax_pkg::OP_FILE_BIT_CLEAR
    |=> !file_mem[$past(instr.faddr)][$past(instr.bsel)] && $stable(status[2:0]);
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear failed"); // [RULE4]

  property p_and_carry;
    @(posedge clk_sys) disable iff (rst)
    exec && instr.op == bax_pkg::OP_AND_IMMEDIATE_WITH_ACC && !bus_wr
    |=> $stable(status[bax_pkg::STAT_DIGIT_CARRY:bax_pkg::STAT_CARRY]);
  endproperty
  a_and_carry: assert property (p_and_carry) else $error("AND touched carry"); // [RULE6]

  property p_skip_nop;
    @(posedge clk_sys) disable iff (rst)
    exec && instr.op == bax_pkg::OP_TEST_BIT_SKIP_WHEN_ONE && fbit
    |=> discard [*4] ##1 (discard != $past(taken));
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skip not two cycles"); // [RULE8]

  property p_rotate_left;
    @(posedge clk_sys) disable iff (rst)
    exec && instr.op == bax_pkg::OP_ROTATE_LEFT_VIA_CARRY && !instr.dest
    |=> acc == {$past(fval[6:0]), $past(status[bax_pkg::STAT_CARRY])}
        && status[bax_pkg::STAT_CARRY] == $past(fval[7]);
  endproperty
  a_rotate_left: assert property (p_rotate_left) else $error("bad rotate"); // [RULE18]

  property p_sleep;
    @(posedge clk_sys) disable iff (rst)
    exec && instr.op == bax_pkg::OP_SLEEP
    |=> watchdog_clear && sleeping && status[bax_pkg::STAT_TIMEOUT_N]
        && !status[bax_pkg::STAT_POWERDOWN_N] ##1 !watchdog_clear;
  endproperty
  a_sleep: assert property (p_sleep) else $error("bad sleep entry"); // [RULE12]

  property p_return;
    @(posedge clk_sys) disable iff (rst)
    exec && instr.op == bax_pkg::OP_RETURN
    |=> pc_load && pc_value == $past(stack_mem[sp - 1'b1]) && $stable(status) ##1 !pc_load;
  endproperty
  a_return: assert property (p_return) else $error("bad return"); // [RULE13]

endmodule
`default_nettype wire

// >>> bench/bax_prog_model.sv
`default_nettype none
module bax_prog_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic instr_ready,
  input wire logic load,
  input wire bax_pkg::bax_instr_s load_instr,
  output var logic instr_valid,
  output var bax_pkg::bax_instr_s instr,
  output var logic empty
);
  bax_pkg::bax_instr_s q[$];
  bax_pkg::bax_instr_s last;
  initial begin
    instr_valid = 1'b0;
    instr = '0;
    empty = 1'b1;
    last = '0;
  end
  always @(posedge clk_sys) begin
    if (rst) begin
      q.delete();
    end else begin
      if (instr_valid && instr_ready) begin
        last = q[0];
        void'(q.pop_front());
      end
      if (load) begin
        q.push_back(load_instr);
      end
    end
    instr_valid <= q.size() != 0;
    empty <= q.size() == 0;
    // an idle fetch port must not keep showing the last word
    instr <= (q.size() != 0) ? q[0] : bax_pkg::bax_instr_s'(~last);
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst, load, call_push, wake, bus_wr, bus_rd, empty, instr_valid;
  logic instr_ready, pc_load, watchdog_clear, sleeping;
  logic [12:0] call_pc, pc_value;
  logic [7:0] acc, status, bus_addr, bus_wdata, bus_rdata;
  bax_pkg::bax_instr_s instr, load_instr;
  int err_total, check_count, n_pc, n_wd;
  bax_core dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .call_push(call_push), .call_pc(call_pc), .pc_load(pc_load),
    .pc_value(pc_value), .watchdog_clear(watchdog_clear), .sleeping(sleeping), .wake(wake),
    .acc(acc), .status(status), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata));
  bax_prog_model pm (.clk_sys(clk_sys), .rst(rst), .instr_ready(instr_ready), .load(load),
    .load_instr(load_instr), .instr_valid(instr_valid), .instr(instr), .empty(empty));
  always @(posedge clk_sys) begin
    if (pc_load === 1'b1) n_pc++;
    if (watchdog_clear === 1'b1) n_wd++;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    @(posedge clk_sys);
    bus_wr <= 1'b1;
    bus_addr <= ad;
    bus_wdata <= v;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk_sys);
    bus_rd <= 1'b1;
    bus_addr <= ad;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 `CHK(bus_rdata, e)
  endtask
  task automatic push(input bax_pkg::bax_op_e op, input logic d, input logic [2:0] b,
    input logic [7:0] k);
    @(posedge clk_sys);
    load <= 1'b1;
    load_instr <= '{op, 7'h7f, d, b, k};
    @(posedge clk_sys);
    load <= 1'b0;
  endtask
  task automatic settle();
    // the queue only fills at the edge that ends push, so wait before looking
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      #1;
      if (empty === 1'b1) break;
    end
    if (empty !== 1'b1) begin
      err_total++;
      $display("FAIL %0t instruction never taken", $time);
      results();
    end
  endtask
  task automatic alu(input bax_pkg::bax_op_e op, input logic [7:0] a, f, k, input logic d,
    input logic [2:0] b, input logic [7:0] st);
    logic [8:0] s;
    logic [7:0] x, r, ea, ef, es;
    logic im;
    es = st;
    ea = a;
    ef = f;
    im = op inside {bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, bax_pkg::OP_AND_IMMEDIATE_WITH_ACC,
      bax_pkg::OP_IMMEDIATE_MINUS_ACC};
    x = im ? k : f;
    case (op)
      bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, bax_pkg::OP_ADD_ACC_TO_FILE: begin
        s = x + a;
        es[0] = s[8];
        es[1] = ({1'b0, x[3:0]} + a[3:0]) > 5'h0f;
      end
      bax_pkg::OP_IMMEDIATE_MINUS_ACC, bax_pkg::OP_FILE_MINUS_ACC: begin
        s = x - a;
        es[0] = x >= a;
        es[1] = x[3:0] >= a[3:0];
      end
      bax_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
        s = {1'b0, f[6:0], st[0]};
        es[0] = f[7];
      end
      bax_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
        s = {1'b0, st[0], f[7:1]};
        es[0] = f[0];
      end
      bax_pkg::OP_FILE_BIT_CLEAR: s = {1'b0, f & ~(8'h01 << b)};
      bax_pkg::OP_FILE_BIT_SET: s = {1'b0, f | (8'h01 << b)};
      default: s = {1'b0, x & a};
    endcase
    r = s[7:0];
    if (!(op inside {bax_pkg::OP_ROTATE_LEFT_VIA_CARRY, bax_pkg::OP_ROTATE_RIGHT_VIA_CARRY,
      bax_pkg::OP_FILE_BIT_CLEAR, bax_pkg::OP_FILE_BIT_SET})) es[2] = r == 8'h00;
    if (im || (!d && !(op inside {bax_pkg::OP_FILE_BIT_CLEAR, bax_pkg::OP_FILE_BIT_SET})))
      ea = r;
    else
      ef = r;
    wr(bax_pkg::ADDR_ACC, a);
    wr(bax_pkg::ADDR_FILE_LAST, f);
    wr(bax_pkg::ADDR_STATUS, st);
    push(op, d, b, k);
    settle();
    rd(bax_pkg::ADDR_ACC, ea);
    rd(bax_pkg::ADDR_FILE_LAST, ef);
    rd(bax_pkg::ADDR_STATUS, es);
    $display("alu op %0d done", op);
  endtask
  task automatic skp(input bax_pkg::bax_op_e op, input logic v, input logic [7:0] e);
    wr(bax_pkg::ADDR_ACC, 8'h00);
    wr(bax_pkg::ADDR_FILE_LAST, {7'h00, v});
    push(op, 1'b0, 3'h0, 8'h00);
    push(bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'h0, 8'h01);
    settle();
    rd(bax_pkg::ADDR_ACC, e);
    $display("skip test done");
  endtask
  task automatic t_reset();
    int n;
    rd(bax_pkg::ADDR_ACC, bax_pkg::ACC_RESET);
    rd(bax_pkg::ADDR_STATUS, bax_pkg::STATUS_RESET);
    rd(bax_pkg::ADDR_CORE, 8'h00);
    wr(8'h90, 8'h55);
    rd(8'h90, 8'h00);
    n = 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      #1 n += (instr_ready === 1'b1);
    end
    `CHK(n, 4)
    $display("reset test done");
  endtask
  task automatic t_ret();
    @(posedge clk_sys);
    call_push <= 1'b1;
    call_pc <= 13'h1abc;
    @(posedge clk_sys);
    call_push <= 1'b0;
    n_pc = 0;
    wr(bax_pkg::ADDR_ACC, 8'h00);
    wr(bax_pkg::ADDR_STATUS, 8'h07);
    push(bax_pkg::OP_RETURN, 1'b0, 3'h0, 8'h00);
    settle();
    repeat (2) @(posedge clk_sys);
    #1 `CHK(n_pc, 1)
    `CHK(pc_value, 13'h1abc)
    // the second cycle of a return swallows the next word
    push(bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'h0, 8'h01);
    settle();
    rd(bax_pkg::ADDR_ACC, 8'h00);
    rd(bax_pkg::ADDR_STATUS, 8'h07);
    $display("return test done");
  endtask
  task automatic t_sleep();
    wr(bax_pkg::ADDR_ACC, 8'h00);
    wr(bax_pkg::ADDR_STATUS, 8'h08);
    n_wd = 0;
    push(bax_pkg::OP_SLEEP, 1'b0, 3'h0, 8'h00);
    settle();
    repeat (3) @(posedge clk_sys);
    #1 `CHK(n_wd, 1)
    `CHK(sleeping, 1'b1)
    rd(bax_pkg::ADDR_STATUS, 8'h10);
    push(bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, 1'b0, 3'h0, 8'h05);
    repeat (12) @(posedge clk_sys);
    rd(bax_pkg::ADDR_ACC, 8'h00);
    @(posedge clk_sys);
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    settle();
    rd(bax_pkg::ADDR_ACC, 8'h05);
    `CHK(sleeping, 1'b0)
    $display("sleep test done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    {load, call_push, wake, bus_wr, bus_rd} = '0;
    {call_pc, bus_addr, bus_wdata} = '0;
    load_instr = '0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    alu(bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, 8'h0f, 8'h00, 8'h01, 0, 0, 8'h18);
    alu(bax_pkg::OP_ADD_IMMEDIATE_TO_ACC, 8'hff, 8'h00, 8'h01, 0, 0, 8'h18);
    alu(bax_pkg::OP_ADD_ACC_TO_FILE, 8'h12, 8'h34, 8'h00, 0, 0, 8'h18);
    alu(bax_pkg::OP_ADD_ACC_TO_FILE, 8'h80, 8'h80, 8'h00, 1, 0, 8'h18);
    alu(bax_pkg::OP_AND_IMMEDIATE_WITH_ACC, 8'hf0, 8'h00, 8'h0f, 0, 0, 8'h1b);
    alu(bax_pkg::OP_AND_ACC_WITH_FILE, 8'h3c, 8'h0f, 8'h00, 1, 0, 8'h1f);
    alu(bax_pkg::OP_AND_ACC_WITH_FILE, 8'h3c, 8'hc3, 8'h00, 0, 0, 8'h18);
    alu(bax_pkg::OP_IMMEDIATE_MINUS_ACC, 8'h01, 8'h00, 8'h00, 0, 0, 8'h1f);
    alu(bax_pkg::OP_IMMEDIATE_MINUS_ACC, 8'h05, 8'h00, 8'h05, 0, 0, 8'h18);
    alu(bax_pkg::OP_FILE_MINUS_ACC, 8'h11, 8'h20, 8'h00, 0, 0, 8'h18);
    alu(bax_pkg::OP_FILE_MINUS_ACC, 8'h20, 8'h10, 8'h00, 1, 0, 8'h18);
    alu(bax_pkg::OP_ROTATE_LEFT_VIA_CARRY, 8'h00, 8'h81, 8'h00, 1, 0, 8'h19);
    alu(bax_pkg::OP_ROTATE_LEFT_VIA_CARRY, 8'h00, 8'h40, 8'h00, 0, 0, 8'h1c);
    alu(bax_pkg::OP_ROTATE_RIGHT_VIA_CARRY, 8'h00, 8'h01, 8'h00, 1, 0, 8'h18);
    alu(bax_pkg::OP_ROTATE_RIGHT_VIA_CARRY, 8'h00, 8'h80, 8'h00, 0, 0, 8'h1d);
    for (int i = 0; i < 8; i++) begin
      alu(bax_pkg::OP_FILE_BIT_CLEAR, 8'h00, 8'hff, 8'h00, 1, i[2:0], 8'h1f);
      alu(bax_pkg::OP_FILE_BIT_SET, 8'h00, 8'h00, 8'h00, 0, i[2:0], 8'h18);
    end
    skp(bax_pkg::OP_TEST_BIT_SKIP_WHEN_ONE, 1'b1, 8'h00);
    skp(bax_pkg::OP_TEST_BIT_SKIP_WHEN_ONE, 1'b0, 8'h01);
    skp(bax_pkg::OP_TEST_BIT_SKIP_WHEN_ZERO, 1'b0, 8'h00);
    skp(bax_pkg::OP_TEST_BIT_SKIP_WHEN_ZERO, 1'b1, 8'h01);
    t_ret();
    t_sleep();
    results();
  end
endmodule
`default_nettype wire
